// File: logic/sebf_defs.svh
`ifndef SEBF_DEFS_SVH
`define SEBF_DEFS_SVH
`define SEBF_TYPE_MAIN 4'b1010
`define SEBF_TYPE_AUX 4'b1011
`define SEBF_FN_IDPAGE 2'b00
`define SEBF_FN_UID 2'b01
`define SEBF_FN_LOCK 2'b10
`define SEBF_FN_PROT 2'b11
`define SEBF_BIT_LAST 3'h7
`define SEBF_FILT_LEN 2'h1
`define SEBF_TINIT_US 100
`define SEBF_CLK_MHZ 100
`define SEBF_SWP_QUARTER 2'b01
`define SEBF_SWP_HALF 2'b10
`define SEBF_SWP_WHOLE 2'b11
`endif

// File: logic/sebf_fifo.sv
`timescale 1ns/10ps
module sebf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wp_q, wp_d, rp_q, rp_d;
   logic push, pop;
   always_comb begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      wp_d = flush_i ? '0 : wp_q + (AW+1)'(push);
      rp_d = flush_i ? '0 : rp_q + (AW+1)'(pop);
   end
   assign in_ready_o = (wp_q - rp_q) != (AW+1)'(DEPTH);
   assign out_valid_o = wp_q != rp_q;
   assign out_data_o = mem_q[rp_q[AW-1:0]];
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_q <= '0;
         rp_q <= '0;
      end else if (en_i) begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
   end
   always_ff @(posedge clock_i) begin
      if (en_i && push && !flush_i) begin
         mem_q[wp_q[AW-1:0]] <= in_data_i;
      end
   end
endmodule

// File: logic/sebf_front_end.sv
// Operation
// - Sample data on clock rise, change own data output after clock fall
// - Bytes MSB first, eight bits then ninth acknowledge clock
// - Any number of bytes accepted between start and stop; write data bytes are not-acknowledged while the write buffer is full
// - Start is data falling while clock high; ignore bus until start
// - Stop is data rising while clock high; ends transaction, releases data
// - Stop after write launches write cycle; otherwise standby
// - Acknowledge drives data low for the whole ninth clock
// - Standby after power-up, stop ending read, internal operation done
// - Ignore commands during power-on reset; brown-out resets and silences
// - Write-protect input high blocks main array and identification page writes
// - Non-volatile soft setting protects selected main array blocks
// - Address byte: type bits 7-4, selects 3-1, direction bit 0
// - Type 1010 main array, 1011 auxiliary space
// - Select bits must match the three select inputs
// - Direction 1 is read, 0 is write
// - Acknowledge address on full match, else not-acknowledge and standby
// - Two word address bytes acknowledged, high byte first
// - Auxiliary function from word bits 10-9
// - Lock uses write direction, unique ID uses read direction
// - Protected write: acknowledge addresses, not-acknowledge data bytes
`timescale 1ns/10ps
`include "sebf_defs.svh"
module sebf_front_end
   import sebf_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int TINIT_CYC = `SEBF_TINIT_US * `SEBF_CLK_MHZ
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic por_ok_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic chip_select_in_0,
   input wire logic chip_select_in_1,
   input wire logic chip_select_in_2,
   input wire logic write_protect_i,
   input wire logic [1:0] soft_block_protect_setting,
   input wire logic identification_page_lock,
   input wire logic wcycle_busy_i,
   input wire logic [7:0] rd_data_i,
   output logic rd_req_o,
   output logic [7:0] wr_data_o,
   output logic wr_valid_o,
   input wire logic wr_ready_i,
   output logic [15:0] word_addr_o,
   output logic aux_space_o,
   output logic [1:0] aux_func_o,
   output logic write_start_o,
   output logic standby_o,
   output logic active_o
);
   // Reset release and pin synchronisers
   logic [1:0] rs_q;
   logic rst_n;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) rs_q <= 2'b00;
      else rs_q <= {rs_q[0], 1'b1};
   end
   assign rst_n = rs_q[1];

   logic [1:0] scl_s_q, sda_s_q, wp_s_q, por_s_q;
   logic [1:0] scl_cnt_q, scl_cnt_d, sda_cnt_q, sda_cnt_d;
   logic scl_f_q, scl_f_d, sda_f_q, sda_f_d;
   // Deglitch: level must hold for one clock more than the filter length before it is accepted
   always_comb begin
      scl_cnt_d = scl_cnt_q;
      scl_f_d = scl_f_q;
      if (scl_s_q[1] == scl_f_q) scl_cnt_d = 2'h0;
      else if (scl_cnt_q == `SEBF_FILT_LEN) begin
         scl_f_d = scl_s_q[1];
         scl_cnt_d = 2'h0;
      end else scl_cnt_d = scl_cnt_q + 2'h1;
      sda_cnt_d = sda_cnt_q;
      sda_f_d = sda_f_q;
      if (sda_s_q[1] == sda_f_q) sda_cnt_d = 2'h0;
      else if (sda_cnt_q == `SEBF_FILT_LEN) begin
         sda_f_d = sda_s_q[1];
         sda_cnt_d = 2'h0;
      end else sda_cnt_d = sda_cnt_q + 2'h1;
   end
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         scl_s_q <= 2'b11;
         sda_s_q <= 2'b11;
         wp_s_q <= 2'b00;
         por_s_q <= 2'b00;
         scl_cnt_q <= 2'h0;
         sda_cnt_q <= 2'h0;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
      end else if (clk_en_i) begin
         scl_s_q <= {scl_s_q[0], scl_i};
         sda_s_q <= {sda_s_q[0], sda_i};
         wp_s_q <= {wp_s_q[0], write_protect_i};
         por_s_q <= {por_s_q[0], por_ok_i};
         scl_cnt_q <= scl_cnt_d;
         sda_cnt_q <= sda_cnt_d;
         scl_f_q <= scl_f_d;
         sda_f_q <= sda_f_d;
      end
   end

   logic scl_p_q, sda_p_q;
   logic scl_rise, scl_fall, start_ev, stop_ev;
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else if (clk_en_i) begin
         scl_p_q <= scl_f_q;
         sda_p_q <= sda_f_q;
      end
   end
   assign scl_rise = scl_f_q && !scl_p_q;
   assign scl_fall = !scl_f_q && scl_p_q;
   assign start_ev = scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
   assign stop_ev = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;

   // Power-up hold-off: commands ignored until supply good and init time spent
   logic [$clog2(TINIT_CYC+1)-1:0] init_q, init_d;
   logic ready;
   always_comb begin
      init_d = init_q;
      if (!por_s_q[1]) init_d = '0;
      else if (!ready) init_d = init_q + 1'b1;
   end
   assign ready = por_s_q[1] && (init_q == ($clog2(TINIT_CYC+1))'(TINIT_CYC));
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) init_q <= '0;
      else if (clk_en_i) init_q <= init_d;
   end

   // Protocol engine
   sebf_state_e st_q, st_d;
   logic [2:0] bit_q, bit_d;
   logic ackph_q, ackph_d;
   logic [7:0] sh_q, sh_d;
   logic drv_q, drv_d;
   logic ackv_q, ackv_d;
   logic aux_q, aux_d;
   logic wrote_q, wrote_d;
   logic [15:0] wa_q, wa_d;
   logic [1:0] fn_q, fn_d;
   logic rdnack_q, rdnack_d;
   logic armed_q, armed_d;
   logic wstart_q, wstart_d;
   logic rreq_q, rreq_d;
   logic push;
   logic [7:0] rcv;
   logic sel_ok, type_ok, prot;
   logic f_in_ready, f_out_valid;
   logic [7:0] f_out_data;

   assign rcv = {sh_q[6:0], sda_f_q};
   assign type_ok = (rcv[7:4] == `SEBF_TYPE_MAIN) || (rcv[7:4] == `SEBF_TYPE_AUX);
   assign sel_ok = rcv[3:1] == {chip_select_in_2, chip_select_in_1, chip_select_in_0};
   // Data byte protection decided from the latched word address
   always_comb begin
      prot = 1'b0;
      if (!aux_q) begin
         prot = wp_s_q[1];
         case (soft_block_protect_setting)
            `SEBF_SWP_QUARTER: prot = prot || (wa_q[15:14] == 2'b11);
            `SEBF_SWP_HALF: prot = prot || wa_q[15];
            `SEBF_SWP_WHOLE: prot = 1'b1;
            default: prot = prot;
         endcase
      end else if (fn_q == `SEBF_FN_IDPAGE) begin
         prot = wp_s_q[1] || identification_page_lock;
      end else if (fn_q == `SEBF_FN_LOCK) begin
         prot = identification_page_lock;
      end else if (fn_q == `SEBF_FN_UID) begin
         prot = 1'b1;
      end
   end

   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      ackph_d = ackph_q;
      sh_d = sh_q;
      drv_d = drv_q;
      ackv_d = ackv_q;
      aux_d = aux_q;
      wrote_d = wrote_q;
      wa_d = wa_q;
      fn_d = fn_q;
      rdnack_d = rdnack_q;
      armed_d = armed_q;
      wstart_d = 1'b0;
      rreq_d = 1'b0;
      push = 1'b0;
      if (!ready) begin
         st_d = SEBF_IDLE;
         drv_d = 1'b0;
      end else if (stop_ev) begin
         // Stop lands in the first clock after a reply, so one bit is counted
         if (st_q == SEBF_WDAT && wrote_q && !ackph_q && bit_q == 3'h1) begin
            wstart_d = 1'b1;
         end
         st_d = SEBF_IDLE;
         drv_d = 1'b0;
         wrote_d = 1'b0;
      end else if (start_ev && !wcycle_busy_i) begin
         st_d = SEBF_DEV;
         bit_d = 3'h0;
         ackph_d = 1'b0;
         drv_d = 1'b0;
         wrote_d = 1'b0;
         armed_d = 1'b0;
      end else if (st_q != SEBF_IDLE && scl_rise) begin
         if (ackph_q) begin
            if (st_q == SEBF_RDAT) rdnack_d = sda_f_q;
         end else if (st_q != SEBF_RDAT) begin
            armed_d = 1'b1;
            sh_d = rcv;
            if (bit_q == `SEBF_BIT_LAST) begin
               case (st_q)
                  SEBF_DEV: begin
                     ackv_d = type_ok && sel_ok;
                     aux_d = rcv[4];
                  end
                  SEBF_WDAT: begin
                     ackv_d = !prot && f_in_ready;
                     push = !prot && f_in_ready;
                     wrote_d = wrote_q || (!prot && f_in_ready);
                  end
                  SEBF_WHI, SEBF_WLO: ackv_d = 1'b1;
                  default: ackv_d = 1'b0;
               endcase
            end
            bit_d = bit_q + 3'h1;
         end
      end else if (st_q != SEBF_IDLE && scl_fall) begin
         // Output changes only after the falling edge
         drv_d = 1'b0;
         // The fall that closes a start must not pass for a reply slot
         if (!ackph_q && bit_q == 3'h0 && st_q != SEBF_RDAT && armed_q) begin
            ackph_d = 1'b1;
            drv_d = ackv_q;
            if (!ackv_q && st_q == SEBF_DEV) st_d = SEBF_IDLE;
         end else if (ackph_q) begin
            ackph_d = 1'b0;
            case (st_q)
               SEBF_DEV: begin
                  if (sh_q[0] && aux_q) st_d = SEBF_RDAT;
                  else if (sh_q[0]) st_d = SEBF_RDAT;
                  else st_d = SEBF_WHI;
               end
               SEBF_WHI: begin
                  wa_d[15:8] = sh_q;
                  fn_d = sh_q[2:1];
                  st_d = SEBF_WLO;
               end
               SEBF_WLO: begin
                  wa_d[7:0] = sh_q;
                  st_d = SEBF_WDAT;
               end
               SEBF_WDAT: wa_d[6:0] = wa_q[6:0] + 7'h1;
               SEBF_RDAT: begin
                  if (rdnack_q) st_d = SEBF_IDLE;
                  else wa_d = wa_q + 16'h1;
               end
               default: st_d = SEBF_IDLE;
            endcase
            if (st_d == SEBF_RDAT) begin
               rreq_d = 1'b1;
               sh_d = rd_data_i;
               drv_d = !rd_data_i[7];
               bit_d = 3'h1;
            end
         end else if (st_q == SEBF_RDAT) begin
            // Counter wrapped: last bit done, line freed for the reply
            if (bit_q == 3'h0) ackph_d = 1'b1;
            else begin
               drv_d = !sh_q[`SEBF_BIT_LAST - bit_q];
               bit_d = bit_q + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= SEBF_IDLE;
         bit_q <= 3'h0;
         ackph_q <= 1'b0;
         sh_q <= 8'h00;
         drv_q <= 1'b0;
         ackv_q <= 1'b0;
         aux_q <= 1'b0;
         wrote_q <= 1'b0;
         wa_q <= 16'h0000;
         fn_q <= 2'b00;
         rdnack_q <= 1'b0;
         armed_q <= 1'b0;
         wstart_q <= 1'b0;
         rreq_q <= 1'b0;
      end else if (clk_en_i) begin
         st_q <= st_d;
         bit_q <= bit_d;
         ackph_q <= ackph_d;
         sh_q <= sh_d;
         drv_q <= drv_d;
         ackv_q <= ackv_d;
         aux_q <= aux_d;
         wrote_q <= wrote_d;
         wa_q <= wa_d;
         fn_q <= fn_d;
         rdnack_q <= rdnack_d;
         armed_q <= armed_d;
         wstart_q <= wstart_d;
         rreq_q <= rreq_d;
      end
   end

   // Write data buffered so array programming may lag the bus
   sebf_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .en_i(clk_en_i),
      .flush_i(start_ev && st_q == SEBF_IDLE && 1'b0),
      .in_valid_i(push),
      .in_ready_o(f_in_ready),
      .in_data_i(rcv),
      .out_valid_o(f_out_valid),
      .out_ready_i(wr_ready_i && !wr_valid_o),
      .out_data_o(f_out_data)
   );

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         sda_o <= 1'b0;
         sda_oe_n_o <= 1'b1;
         wr_valid_o <= 1'b0;
         wr_data_o <= 8'h00;
         word_addr_o <= 16'h0000;
         aux_space_o <= 1'b0;
         aux_func_o <= 2'b00;
         write_start_o <= 1'b0;
         rd_req_o <= 1'b0;
         standby_o <= 1'b1;
         active_o <= 1'b0;
      end else if (clk_en_i) begin
         sda_o <= 1'b0;
         sda_oe_n_o <= !drv_q;
         wr_valid_o <= f_out_valid && wr_ready_i && !wr_valid_o;
         wr_data_o <= f_out_data;
         word_addr_o <= wa_q;
         aux_space_o <= aux_q;
         aux_func_o <= fn_q;
         write_start_o <= wstart_q;
         rd_req_o <= rreq_q;
         standby_o <= (st_q == SEBF_IDLE) && !wcycle_busy_i;
         active_o <= st_q != SEBF_IDLE;
      end
   end
endmodule

// File: logic/sebf_pkg.sv
package sebf_pkg;
   typedef enum logic [2:0] {
      SEBF_IDLE = 3'b000,
      SEBF_DEV = 3'b001,
      SEBF_WHI = 3'b010,
      SEBF_WLO = 3'b011,
      SEBF_WDAT = 3'b100,
      SEBF_RDAT = 3'b101
   } sebf_state_e;
   typedef enum logic [1:0] {
      SEBF_OP_MAIN = 2'b00,
      SEBF_OP_AUX = 2'b01
   } sebf_space_e;
endpackage

// File: testbench/sebf_bus_ctrl.sv
`timescale 1ns/10ps
module sebf_bus_ctrl (
   input wire logic sda_line_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Data moves mid low phase only
   task automatic bit_out(input logic b);
      #31.25 sda_o = b;
      #31.25 scl_o = 1'b1;
      #62.5 scl_o = 1'b0;
   endtask
   task automatic start();
      #31.25 sda_o = 1'b1;
      #31.25 scl_o = 1'b1;
      #31.25 sda_o = 1'b0;
      #31.25 scl_o = 1'b0;
   endtask
   // Clock stands high after stop
   task automatic stop();
      #31.25 sda_o = 1'b0;
      #31.25 scl_o = 1'b1;
      #31.25 sda_o = 1'b1;
      #62.5;
   endtask
   task automatic put_byte(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--) bit_out(v[i]);
      #31.25 sda_o = 1'b1;
      #31.25 scl_o = 1'b1;
      #56 ack = !sda_line_i;
      #6.5 scl_o = 1'b0;
   endtask
   task automatic get_byte(input logic last, output logic [7:0] v);
      sda_o = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         #62.5 scl_o = 1'b1;
         #56 v[i] = sda_line_i;
         #6.5 scl_o = 1'b0;
      end
      bit_out(last);
   endtask
   task automatic recover();
      start();
      repeat (9) bit_out(1'b1);
      start();
      stop();
   endtask
endmodule

// File: testbench/sebf_front_end_monitor.sv
`timescale 1ns/10ps
module sebf_front_end_monitor (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic por_ok_i,
   input wire logic write_protect_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic rd_req_o,
   input wire logic [15:0] word_addr_o,
   input wire logic [1:0] aux_func_o,
   input wire logic write_start_o,
   input wire logic standby_o,
   input wire logic active_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   property p_ack_low;
      !sda_oe_n_o |-> !sda_o;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("driven level not low");
   property p_por_quiet;
      !por_ok_i [*5] |-> sda_oe_n_o;
   endproperty
   a_por_quiet: assert property (p_por_quiet) else $error("drive without supply");
   property p_rst_standby;
      $rose(rst_n_i) |-> standby_o && sda_oe_n_o;
   endproperty
   a_rst_standby: assert property (p_rst_standby) else $error("no standby at reset");
   property p_ws_pulse;
      write_start_o |=> !write_start_o;
   endproperty
   a_ws_pulse: assert property (p_ws_pulse) else $error("write start too long");
   property p_rd_pulse;
      rd_req_o |=> !rd_req_o;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read request too long");
   property p_stop_release;
      $rose(standby_o) |-> sda_oe_n_o;
   endproperty
   a_stop_release: assert property (p_stop_release) else $error("line held in standby");
   property p_func_hold;
      !active_o && $past(!active_o) |-> $stable(aux_func_o);
   endproperty
   a_func_hold: assert property (p_func_hold) else $error("function moved idle");
   property p_addr_hold;
      standby_o && $past(standby_o) |-> $stable(word_addr_o);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved idle");
   property p_wp_block;
      write_protect_i [*8] |-> !write_start_o;
   endproperty
   a_wp_block: assert property (p_wp_block) else $error("protected write started");
endmodule
bind sebf_front_end sebf_front_end_monitor mon (.clock_i, .rst_n_i, .por_ok_i,
   .write_protect_i, .sda_o, .sda_oe_n_o, .rd_req_o, .word_addr_o, .aux_func_o,
   .write_start_o, .standby_o, .active_o);

// File: testbench/test_serial_eeprom_bus_front_end.sv
`timescale 1ns/10ps
module test_serial_eeprom_bus_front_end;
   localparam logic [2:0] CS = 3'b101;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic por_ok_i = 1'b0;
   logic wp = 1'b0;
   logic busy = 1'b0;
   logic wr_ready = 1'b0;
   logic [2:0] cs = CS;
   logic [7:0] rd_data = 8'h00;
   logic scl, ctl_sda, sda_oe_n, sda_drv, rd_req, wr_valid, aux_space, wstart, standby, active;
   logic [7:0] wr_data, wr_first, v;
   logic [15:0] word_addr;
   logic [1:0] aux_func;
   logic ack;
   wire sda_line = ctl_sda & (sda_oe_n | sda_drv);
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   int wr_cnt = 0;
   int ws_cnt = 0;
   int rq_cnt = 0;
   always #5 clock_i = ~clock_i;
   sebf_front_end #(.TINIT_CYC(20)) uut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .por_ok_i(por_ok_i),
      .scl_i(scl), .sda_i(sda_line), .sda_o(sda_drv), .sda_oe_n_o(sda_oe_n),
      .chip_select_in_0(cs[0]), .chip_select_in_1(cs[1]), .chip_select_in_2(cs[2]),
      .write_protect_i(wp), .soft_block_protect_setting(2'b00), .identification_page_lock(1'b0),
      .wcycle_busy_i(busy), .rd_data_i(rd_data), .rd_req_o(rd_req),
      .wr_data_o(wr_data), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
      .word_addr_o(word_addr), .aux_space_o(aux_space), .aux_func_o(aux_func),
      .write_start_o(wstart), .standby_o(standby), .active_o(active));
   sebf_bus_ctrl ctrl (.sda_line_i(sda_line), .scl_o(scl), .sda_o(ctl_sda));
   always @(posedge clock_i) begin
      cycles++;
      if (wr_valid === 1'b1 && wr_ready) begin
         if (wr_cnt == 0) wr_first = wr_data;
         wr_cnt++;
      end
      if (wstart === 1'b1) ws_cnt++;
      if (rd_req === 1'b1) rq_cnt++;
      if (cycles == 30000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic addr(input logic [7:0] b);
      ctrl.start();
      ctrl.put_byte(b, ack);
   endtask
   task automatic settle();
      repeat (30) @(posedge clock_i);
      @(negedge clock_i);
   endtask
   task automatic t_power();
      addr({4'b1010, CS, 1'b0});
      check(ack, 1'b0);
      ctrl.stop();
      check(standby, 1'b1);
      @(negedge clock_i);
      por_ok_i = 1'b1;
      settle();
      $display("power test done");
   endtask
   task automatic t_fill();
      addr({4'b1010, CS, 1'b0});
      check(ack, 1'b1);
      ctrl.put_byte(8'h12, ack);
      check(ack, 1'b1);
      ctrl.put_byte(8'h34, ack);
      check(ack, 1'b1);
      check(aux_space, 1'b0);
      // Far side stalls so the buffer must refuse the last byte
      for (int i = 0; i < 17; i++) begin
         ctrl.put_byte(8'h40 + i[7:0], ack);
         // Address still unincremented as the first data reply ends
         if (i == 0) check(word_addr, 16'h1234);
         check(ack, i < 16);
      end
      ctrl.stop();
      settle();
      check(16'(ws_cnt), 16'h0001);
      wr_ready = 1'b1;
      settle();
      settle();
      check(16'(wr_cnt), 16'h0010);
      check(wr_first, 8'h40);
      $display("fill test done");
   endtask
   task automatic t_wp();
      wp = 1'b1;
      addr({4'b1010, CS, 1'b0});
      check(ack, 1'b1);
      ctrl.put_byte(8'h00, ack);
      check(ack, 1'b1);
      ctrl.put_byte(8'h10, ack);
      check(ack, 1'b1);
      ctrl.put_byte(8'h5A, ack);
      check(ack, 1'b0);
      ctrl.stop();
      settle();
      check(16'(ws_cnt), 16'h0001);
      wp = 1'b0;
      $display("protect test done");
   endtask
   task automatic t_aux();
      for (int f = 0; f < 4; f++) begin
         addr({4'b1011, CS, 1'b0});
         check(ack, 1'b1);
         ctrl.put_byte({5'h00, f[1:0], 1'b0}, ack);
         ctrl.put_byte(8'h03, ack);
         check(aux_space, 1'b1);
         check(aux_func, f[1:0]);
         ctrl.stop();
      end
      $display("aux test done");
   endtask
   task automatic t_read();
      settle();
      rd_data = 8'hC6;
      addr({4'b1010, CS, 1'b1});
      check(ack, 1'b1);
      ctrl.get_byte(1'b1, v);
      check(v, 8'hC6);
      ctrl.stop();
      settle();
      check(standby, 1'b1);
      check(16'(ws_cnt), 16'h0001);
      check(16'(rq_cnt), 16'h0001);
      check(active, 1'b0);
      $display("read test done");
   endtask
   task automatic t_refuse();
      cs = 3'b110;
      addr({4'b1010, CS, 1'b0});
      check(ack, 1'b0);
      ctrl.stop();
      settle();
      check(standby, 1'b1);
      cs = CS;
      busy = 1'b1;
      addr({4'b1010, CS, 1'b0});
      check(ack, 1'b0);
      ctrl.stop();
      settle();
      busy = 1'b0;
      addr({4'b1100, CS, 1'b0});
      check(ack, 1'b0);
      ctrl.recover();
      addr({4'b1010, CS, 1'b1});
      check(ack, 1'b1);
      ctrl.get_byte(1'b1, v);
      check(v, 8'hC6);
      ctrl.stop();
      $display("refuse test done");
   endtask
   initial begin
      repeat (2) @(negedge clock_i);
      rst_n_i = 1'b1;
      t_power();
      t_fill();
      t_wp();
      t_aux();
      t_read();
      t_refuse();
      wrap_up();
   end
endmodule
